/* File: rtl/wdp_pkg.sv */
/*
  Shared constants and types of the watchdog with prescaler block:
  register indices, field positions, reset values, timing figures.
  Assumes a 40 MHz system clock and a 32-bit classic Wishbone bus.
*/
package wdp_pkg;

  // Bus geometry
  localparam int unsigned WB_ADR_W = 16;
  localparam int unsigned WB_DAT_W = 32;
  localparam int unsigned RD_W     = 16;

  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_OPTION = 14'h0081;
  localparam logic [13:0] IDX_CONFIG = 14'h2007;
  localparam logic [13:0] IDX_STATUS = 14'h0003;
  localparam logic [13:0] IDX_CMD    = 14'h0004;
  localparam logic [13:0] IDX_ISTAT  = 14'h0005;
  localparam logic [13:0] IDX_IMASK  = 14'h0006;
  localparam logic [1:0]  ADR_ALIGN  = 2'h0;

  // Timer/prescale configuration register
  localparam int unsigned OPT_W          = 8;
  localparam logic [7:0]  OPT_RST        = 8'hff;
  localparam int unsigned OPT_ASSIGN_BIT = 3;
  localparam int unsigned OPT_RATE_MSB   = 2;
  localparam int unsigned OPT_RATE_LSB   = 0;

  // Device configuration word
  localparam int unsigned CFG_W          = 14;
  localparam int unsigned CFG_PWRT_BIT   = 3;
  localparam int unsigned CFG_WDT_EN_BIT = 2;
  localparam int unsigned CFG_OSC_MSB    = 1;
  localparam int unsigned CFG_OSC_LSB    = 0;
  localparam logic [1:0]  OSC_LP         = 2'h0;
  localparam logic [1:0]  OSC_XT         = 2'h1;
  localparam logic [1:0]  OSC_HS         = 2'h2;
  localparam logic [1:0]  OSC_RC         = 2'h3;

  // Status, command and interrupt fields
  localparam int unsigned STAT_TO_BIT    = 0;
  localparam int unsigned STAT_SLEEP_BIT = 1;
  localparam int unsigned CMD_CLR_BIT    = 0;
  localparam int unsigned CMD_SLEEP_BIT  = 1;
  localparam int unsigned IRQ_W          = 2;
  localparam int unsigned IRQ_RESET_BIT  = 0;
  localparam int unsigned IRQ_WAKE_BIT   = 1;
  localparam logic [1:0]  IRQ_RST        = 2'h0;

  // Timing: base period of the watchdog oscillator
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned WDT_PERIOD_US  = 18000;
  localparam int unsigned NS_PER_US      = 1000;
  localparam int unsigned WDT_BASE_CYC   =
    (WDT_PERIOD_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int unsigned BASE_W         = 20;
  localparam int unsigned PRE_W          = 7;

  // Run state of the device
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_SLEEP = 2'b10
  } wdp_state_t;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    RS_NONE, RS_OPT, RS_CFG, RS_STAT, RS_CMD, RS_ISTAT, RS_IMASK
  } wdp_regsel_t;

endpackage

/* File: rtl/wdp_prescaler.sv */
/*
  Shared prescaler as seen by the watchdog: divides base time-outs
  by 1 to 128 in powers of two. Assumes the caller holds it clear
  while it is not assigned and keeps tick a one-cycle pulse.
*/
`timescale 1ns/100ps
module wdp_prescaler
  import wdp_pkg::*;
(
  input  wire logic       clk,      // System clock
  input  wire logic       rst_n,    // Synchronous reset, active low
  input  wire logic       clear,    // Zero the count
  input  wire logic       tick,     // Base period elapsed
  input  wire logic       assigned, // Prescaler serves the watchdog
  input  wire logic [2:0] rate,     // Division select
  output logic            expire    // Watchdog time-out pulse
);

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } wdp_pre_t;

  wdp_pre_t         s_r;
  wdp_pre_t         s_nxt;
  logic [PRE_W-1:0] lastCnt;

  // Terminal count has rate low bits set: ratio 2**rate
  genvar i;
  generate
    for (i = 0; i < PRE_W; i++) begin : g_mask
      assign lastCnt[i] = (rate > 3'(i));
    end
  endgenerate

  // Unassigned means every base period expires
  assign expire = tick & (~assigned | (s_r.cnt == lastCnt));

  // Count base periods, restart after each time-out
  always_comb begin
    s_nxt = s_r;
    if (!rst_n || clear || expire) begin
      s_nxt.cnt = '0;
    end else if (tick && assigned) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  ratio_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && assigned && s_r.cnt != lastCnt) |-> !expire)
    else $error("prescaler expired before its terminal count");

  count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && assigned && !clear && !expire)
      |=> (s_r.cnt == $past(s_r.cnt) + 1'b1))
    else $error("prescaler missed a base period");

endmodule

/* File: rtl/wdp_watchdog.sv */
/*
  Watchdog timer with shared prescaler, run-state tracking and a
  classic Wishbone register slave with a level interrupt.
  Assumes a single 40 MHz clock, synchronous active-low reset, and
  configuration fuses that are stable while reset is asserted.
*/
// What this block does
// - Counts from its own free-running time base
// - Keeps counting while the core sleeps
// - Expiry in normal run resets the device
// - Expiry in sleep wakes the device instead
// - Enable fuse at zero disables it forever
// - Base time-out is 18 ms without prescaler
// - Assigned prescaler stretches time-out up to 1:128
// - Clear or sleep command zeroes count, prescaler
// - Every expiry clears the time-out status flag
// - Option register resets to ff; assign, rate
// - Two fuses pick one of four oscillators
`timescale 1ns/100ps
module wdp_watchdog
  import wdp_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = WDT_BASE_CYC // Shorten in sim
)
(
  input  wire logic                clk,          // 40 MHz clock
  input  wire logic                rst_n,        // Sync reset, low
  input  wire logic [CFG_W-1:0]    cfgWord,      // Fuse word
  input  wire logic                wb_cyc_i,     // Bus cycle
  input  wire logic                wb_stb_i,     // Bus strobe
  input  wire logic                wb_we_i,      // Write enable
  input  wire logic [WB_ADR_W-1:0] wb_adr_i,     // Byte address
  input  wire logic [WB_DAT_W-1:0] wb_dat_i,     // Write data
  input  wire logic [3:0]          wb_sel_i,     // Byte lanes
  output logic      [WB_DAT_W-1:0] wb_dat_o,     // Read data
  output logic                     wb_ack_o,     // Acknowledge
  output logic                     irq,          // Interrupt level
  output logic                     deviceReset,  // Reset pulse
  output logic                     wakeUp,       // Wake pulse
  output logic                     sleeping,     // Core in sleep
  output logic                     timeoutStatusN, // Low: timed out
  output logic                     powerUpDelayEn, // Fuse bit, low on
  output logic      [3:0]          oscModeSel    // One-hot osc mode
);

  typedef struct packed {
    wdp_state_t       state;
    logic [BASE_W-1:0] base;
    logic [OPT_W-1:0] option;
    logic [CFG_W-1:0] cfg;
    logic             tosN;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic             ack;
    logic [RD_W-1:0]  rdata;
    logic             rstPulse;
    logic             wakePulse;
  } wdp_regs_t;

  wdp_regs_t         s_r;
  wdp_regs_t         s_nxt;
  logic [BASE_W-1:0] baseLast;
  logic              wdtOn;
  logic              baseTick;
  logic              expire;
  logic              busReq;
  logic              wrDone;
  logic              cmdClr;
  logic              cmdSleep;
  logic              wdtClear;
  logic              preAssigned;
  logic              preClear;
  wdp_regsel_t       selId;

  // Map a byte address onto a register; misaligned reads as none
  function automatic wdp_regsel_t regSel(
    input logic [WB_ADR_W-1:0] adr
  );
    wdp_regsel_t r;
    r = RS_NONE;
    if (adr[1:0] == ADR_ALIGN) begin
      case (adr[WB_ADR_W-1:2])
        IDX_OPTION: r = RS_OPT;
        IDX_CONFIG: r = RS_CFG;
        IDX_STATUS: r = RS_STAT;
        IDX_CMD:    r = RS_CMD;
        IDX_ISTAT:  r = RS_ISTAT;
        IDX_IMASK:  r = RS_IMASK;
        default:    r = RS_NONE;
      endcase
    end
    return r;
  endfunction

  // Bus decode: a write lands on the edge where ack is seen high
  assign busReq   = wb_cyc_i & wb_stb_i;
  assign selId    = regSel(wb_adr_i);
  assign wrDone   = busReq & wb_we_i & s_r.ack & wb_sel_i[0];
  assign cmdClr   = wrDone & (selId == RS_CMD)
                    & wb_dat_i[CMD_CLR_BIT];
  assign cmdSleep = wrDone & (selId == RS_CMD)
                    & wb_dat_i[CMD_SLEEP_BIT] & (s_r.state == ST_RUN);
  assign wdtClear = cmdClr | cmdSleep;

  // Base time-out. The on-chip oscillator is modelled as a count of
  // system clocks that never stops for sleep; real silicon would
  // drift with supply and temperature, this does not.
  assign baseLast = BASE_W'(BASE_CYCLES - 1);
  assign wdtOn    = s_r.cfg[CFG_WDT_EN_BIT];
  assign baseTick = wdtOn & (s_r.base == baseLast);

  // Prescaler only serves the watchdog while assigned to it
  assign preAssigned = s_r.option[OPT_ASSIGN_BIT];
  assign preClear    = ~wdtOn | ~preAssigned
                       | (wdtClear & preAssigned);

  wdp_prescaler u_prescaler (
    .clk      (clk),
    .rst_n    (rst_n),
    .clear    (preClear),
    .tick     (baseTick),
    .assigned (preAssigned),
    .rate     (s_r.option[OPT_RATE_MSB:OPT_RATE_LSB]),
    .expire   (expire)
  );

  // Next-state logic: bus writes first, hardware events after,
  // so a hardware set or a watchdog reset always wins a clear
  always_comb begin
    s_nxt           = s_r;
    s_nxt.ack       = busReq & ~s_r.ack;
    s_nxt.rstPulse  = 1'b0;
    s_nxt.wakePulse = 1'b0;

    // Read data captured as ack rises, held while ack stands
    if (busReq && !s_r.ack) begin
      s_nxt.rdata = '0;
      case (selId)
        RS_OPT:   s_nxt.rdata[OPT_W-1:0] = s_r.option;
        RS_CFG:   s_nxt.rdata[CFG_W-1:0] = s_r.cfg;
        RS_STAT: begin
          s_nxt.rdata[STAT_TO_BIT]    = s_r.tosN;
          s_nxt.rdata[STAT_SLEEP_BIT] = (s_r.state == ST_SLEEP);
        end
        RS_ISTAT: s_nxt.rdata[IRQ_W-1:0] = s_r.istat;
        RS_IMASK: s_nxt.rdata[IRQ_W-1:0] = s_r.imask;
        default:  s_nxt.rdata = '0;
      endcase
    end

    // Register writes; command register is write-only
    if (wrDone) begin
      case (selId)
        RS_OPT:   s_nxt.option = wb_dat_i[OPT_W-1:0];
        RS_ISTAT: s_nxt.istat  = s_r.istat & ~wb_dat_i[IRQ_W-1:0];
        RS_IMASK: s_nxt.imask  = wb_dat_i[IRQ_W-1:0];
        default:  s_nxt.imask  = s_nxt.imask;
      endcase
    end

    // Base counter runs in every state, wraps each period
    if (!wdtOn || wdtClear || baseTick) begin
      s_nxt.base = '0;
    end else begin
      s_nxt.base = s_r.base + 1'b1;
    end

    // Run state and time-out consequences
    if (expire) begin
      s_nxt.tosN = 1'b0;
      if (s_r.state == ST_RUN) begin
        s_nxt.rstPulse = 1'b1;
        s_nxt.option   = OPT_RST;
        s_nxt.istat[IRQ_RESET_BIT] = 1'b1;
      end else begin
        s_nxt.state     = ST_RUN;
        s_nxt.wakePulse = 1'b1;
        s_nxt.istat[IRQ_WAKE_BIT] = 1'b1;
      end
    end else if (cmdSleep) begin
      s_nxt.state = ST_SLEEP;
      s_nxt.tosN  = 1'b1;
    end else if (cmdClr) begin
      s_nxt.tosN  = 1'b1;
    end

    // Reset; fuses are sampled while reset is held
    if (!rst_n) begin
      s_nxt.state     = ST_RUN;
      s_nxt.base      = '0;
      s_nxt.option    = OPT_RST;
      s_nxt.cfg       = cfgWord;
      s_nxt.tosN      = 1'b1;
      s_nxt.istat     = IRQ_RST;
      s_nxt.imask     = IRQ_RST;
      s_nxt.ack       = 1'b0;
      s_nxt.rdata     = '0;
      s_nxt.rstPulse  = 1'b0;
      s_nxt.wakePulse = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  // Oscillator mode from the two fuse bits
  always_comb begin
    case (s_r.cfg[CFG_OSC_MSB:CFG_OSC_LSB])
      OSC_LP:  oscModeSel = 4'h1;
      OSC_XT:  oscModeSel = 4'h2;
      OSC_HS:  oscModeSel = 4'h4;
      OSC_RC:  oscModeSel = 4'h8;
      default: oscModeSel = 4'h1;
    endcase
  end

  // Outputs, all taken from state flops
  assign wb_dat_o       = {{(WB_DAT_W - RD_W){1'b0}}, s_r.rdata};
  assign wb_ack_o       = s_r.ack;
  assign irq            = |(s_r.istat & s_r.imask);
  assign deviceReset    = s_r.rstPulse;
  assign wakeUp         = s_r.wakePulse;
  assign sleeping       = (s_r.state == ST_SLEEP);
  assign timeoutStatusN = s_r.tosN;
  assign powerUpDelayEn = s_r.cfg[CFG_PWRT_BIT];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  run_expiry_a: assert property (
    (expire && s_r.state == ST_RUN)
      |=> (deviceReset && !wakeUp && s_r.option == OPT_RST))
    else $error("run-time expiry did not reset the device");

  sleep_wake_a: assert property (
    (expire && s_r.state == ST_SLEEP)
      |=> (wakeUp && !deviceReset && !sleeping))
    else $error("sleep expiry did not wake the device");

  fuse_off_a: assert property (
    !wdtOn |-> (!expire && s_r.base == '0))
    else $error("disabled watchdog is counting");

  status_clear_a: assert property (
    expire |=> !timeoutStatusN)
    else $error("time-out flag not cleared on expiry");

  clear_cmd_a: assert property (
    (wdtClear && !expire) |=> (s_r.base == '0 && timeoutStatusN))
    else $error("clear command left the count running");

  // A clear written during sleep legally zeroes the count
  sleep_count_a: assert property (
    (sleeping && wdtOn && !baseTick && !wdtClear)
      |=> (s_r.base == $past(s_r.base) + 1'b1))
    else $error("watchdog stalled during sleep");

  period_restart_a: assert property (
    baseTick |=> (s_r.base == '0)
      ##1 ($past(wdtClear) || s_r.base == BASE_W'(1)))
    else $error("base period did not restart from zero");

  no_early_tick_a: assert property (
    (s_r.base != baseLast) |-> !baseTick)
    else $error("base period ended early");

  bus_ack_a: assert property (
    (busReq && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after request");

endmodule

/* File: sim/wdp_watchdog_tb.sv */
/*
  Self-checking bench of the watchdog block: drives the Wishbone port
  and the fuse word, times the reset and wake pulses against the base
  period. Assumes a 40 MHz clock and a shortened base period.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  checksDone++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("ERROR at %0t got %0h exp %0h", $time, (got), (exp)); \
  end \
end
module wdp_watchdog_tb
  import wdp_pkg::*;
;
  // Short base period keeps the 1:128 case within a few thousand cycles
  localparam int unsigned BASE   = 16;
  localparam logic [15:0] A_OPT  = {IDX_OPTION, ADR_ALIGN};
  localparam logic [15:0] A_CFG  = {IDX_CONFIG, ADR_ALIGN};
  localparam logic [15:0] A_STAT = {IDX_STATUS, ADR_ALIGN};
  localparam logic [15:0] A_CMD  = {IDX_CMD, ADR_ALIGN};
  localparam logic [15:0] A_IST  = {IDX_ISTAT, ADR_ALIGN};
  localparam logic [15:0] A_IMSK = {IDX_IMASK, ADR_ALIGN};
  localparam logic [15:0] A_NONE = 16'h0100;

  logic                clk;
  logic                rst_n;
  logic [CFG_W-1:0]    cfgWord;
  logic                wbCyc;
  logic                wbStb;
  logic                wbWe;
  logic [WB_ADR_W-1:0] wbAdr;
  logic [WB_DAT_W-1:0] wbDatW;
  logic [3:0]          wbSel;
  logic [WB_DAT_W-1:0] wbDatR;
  logic                wbAck;
  logic                irq;
  logic                deviceReset;
  logic                wakeUp;
  logic                sleeping;
  logic                timeoutStatusN;
  logic                powerUpDelayEn;
  logic [3:0]          oscModeSel;
  logic [31:0]         rd;
  logic [CFG_W-1:0]    cw;
  int                  errors = 0;
  int                  checksDone = 0;
  int                  resetsSeen = 0;
  int                  wakesSeen = 0;
  int                  n;
  int                  r0;

  wdp_watchdog #(.BASE_CYCLES(BASE)) i_wdp_watchdog (
    .clk(clk), .rst_n(rst_n), .cfgWord(cfgWord),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .irq(irq),
    .deviceReset(deviceReset), .wakeUp(wakeUp), .sleeping(sleeping),
    .timeoutStatusN(timeoutStatusN), .powerUpDelayEn(powerUpDelayEn),
    .oscModeSel(oscModeSel)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Pulses are one cycle wide, so each edge seen high is one event
  always @(posedge clk) begin
    if (deviceReset === 1'b1) resetsSeen++;
    if (wakeUp === 1'b1) wakesSeen++;
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Fuses are captured while reset is low, so they change with it
  task automatic doReset(input logic [CFG_W-1:0] cfg);
    cfgWord <= cfg;
    rst_n   <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  // One classic cycle; idle edge first so cyc/stb drop between cycles
  task automatic wbXfer(input logic we, input logic [15:0] adr,
                        input logic [31:0] dat, output logic [31:0] q);
    int k;
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbDatW <= dat;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wbAck !== 1'b1 && k < 50);
    `CHK(wbAck, 1'b1)
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  task automatic wbWrite(input logic [15:0] adr, input logic [31:0] dat);
    logic [31:0] q;
    wbXfer(1'b1, adr, dat, q);
  endtask

  task automatic wbRead(input logic [15:0] adr, output logic [31:0] q);
    wbXfer(1'b0, adr, 32'h0, q);
  endtask

  // Edges from the edge of a command to the first reset or wake pulse
  task automatic waitPulse(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (deviceReset !== 1'b1 && wakeUp !== 1'b1 && cnt < 3000);
  endtask

  // Hang guard: the tests need well under 10000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    finish_test;
  end

  initial begin
    wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0; wbSel <= 4'hf;
    wbAdr <= 16'h0; wbDatW <= 32'h0;
    // Every oscillator mode and both power-up delay settings
    for (int m = 0; m < 4; m++) begin
      cw = {10'h0, m[0], 1'b1, m[1:0]};
      doReset(cw);
      wbRead(A_CFG, rd);
      `CHK(rd, {18'h0, cw})
      `CHK(oscModeSel, 4'h1 << m)
      `CHK(powerUpDelayEn, m[0])
    end
    // Reset values, read-only and unmapped places
    wbRead(A_OPT, rd);   `CHK(rd, 32'hff)
    wbRead(A_STAT, rd);  `CHK(rd, 32'h1)
    wbRead(A_IMSK, rd);  `CHK(rd, 32'h0)
    wbWrite(A_CFG, 32'h0);
    wbWrite(A_NONE, 32'hff);
    wbRead(A_CFG, rd);   `CHK(rd, {18'h0, cw})
    wbRead(A_NONE, rd);  `CHK(rd, 32'h0)
    wbWrite(A_IMSK, 32'h3);
    // Period unassigned, then each prescale rate 1:1 to 1:128
    for (int i = 0; i < 9; i++) begin
      wbWrite(A_CMD, 32'h1);
      wbWrite(A_OPT, (i == 0) ? 32'h0 : 32'h8 | (i - 1));
      wbWrite(A_CMD, 32'h1);
      waitPulse(n);
      `CHK(n, BASE * ((i == 0) ? 1 : 1 << (i - 1)) + 1)
      `CHK(deviceReset, 1'b1)
      @(negedge clk);
      `CHK(timeoutStatusN, 1'b0)
      `CHK(irq, 1'b1)
      wbRead(A_OPT, rd);  `CHK(rd, 32'hff)
      wbWrite(A_IST, 32'h1);
      @(negedge clk);
      `CHK(irq, 1'b0)
    end
    // Clears every 20 cycles at 1:2 must hold off any expiry
    wbWrite(A_OPT, 32'h9);
    r0 = resetsSeen;
    repeat (6) begin
      wbWrite(A_CMD, 32'h1);
      repeat (17) @(posedge clk);
    end
    `CHK(resetsSeen, r0)
    `CHK(timeoutStatusN, 1'b1)
    // Count runs on in sleep and expiry wakes without a reset
    wbWrite(A_OPT, 32'h8);
    wbWrite(A_CMD, 32'h2);
    @(negedge clk);
    `CHK(sleeping, 1'b1)
    waitPulse(n);
    `CHK(n, BASE + 1)
    `CHK(wakeUp, 1'b1)
    `CHK(sleeping, 1'b0)
    `CHK(resetsSeen, r0)
    wbRead(A_STAT, rd);  `CHK(rd, 32'h0)
    wbRead(A_OPT, rd);   `CHK(rd, 32'h8)
    wbRead(A_IST, rd);   `CHK(rd, 32'h2)
    // Mask hides the pending wake event, write-one clears it
    wbWrite(A_IMSK, 32'h0);
    @(negedge clk);
    `CHK(irq, 1'b0)
    wbWrite(A_IMSK, 32'h2);
    @(negedge clk);
    `CHK(irq, 1'b1)
    wbWrite(A_IST, 32'h2);
    @(negedge clk);
    `CHK(irq, 1'b0)
    // Enable fuse low: nothing ever expires
    doReset(14'h000b);
    r0 = resetsSeen + wakesSeen;
    wbWrite(A_OPT, 32'h0);
    repeat (300) @(posedge clk);
    `CHK(resetsSeen + wakesSeen, r0)
    `CHK(timeoutStatusN, 1'b1)
    finish_test;
  end
endmodule
